// ===== design/watchdog_timeout_prescaler.sv
/*
 watchdog time-out prescaler with wishbone classic slave, timed unlock and interrupt.
 assumes a wishbone classic master on ref_clk and that the core pulses the command
 register for the restart instruction and for entry to the watchdog vector.
*/
// Operation
// (R01) while enabled, four-bit timeout_select (bits 5 and 2:0) sets the time-out count
// (R02) count is 512 oscillator cycles doubled per code step, up to 256K
// (R03) reserved codes 1010 to 1111 are replaced by a valid code below 1010
// (R04) software writes the unlock signature, then the field within four cycles
// (R05) timeout_select writes outside the four-cycle unlock window are rejected
// (R06) a watchdog reset requests execution from reset vector 0x0000
// (R07) the counter advances only on the 32 kHz oscillator tick
// (R08) irq enable turns time-out into interrupt; with reset enable, hardware clears it
// (R09) interrupt time-out sets the flag; vector entry or write-one clears it
// (R10) counter clears on restart, when disabled, and on chip reset
// (R11) time-out fires on the tick where the count reaches the selected count
`timescale 1ns/100ps
module watchdog_timeout_prescaler #(
	parameter int OSC_DIV = wdt_pkg::OSC_DIV
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq,
	output logic timeoutIrqFlag,
	output logic resetReq,
	output logic [15:0] resetVector
);
	import wdt_pkg::*;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [3:0] tsel;
		logic irqEn;
		logic rstEn;
		logic flag;
		logic [2:0] unlock;
		logic [CNT_W-1:0] cnt;
		logic [EVT_W-1:0] sts;
		logic [EVT_W-1:0] mask;
		logic irq;
		logic rstReq;
		logic [15:0] vec;
	} state_s;

	state_s s_q;
	state_s s_d;
	logic tick;
	logic acc;
	logic wr;
	logic rd;
	logic enabled;
	logic timeout;
	logic restart;
	logic [CNT_W-1:0] limit;
	logic [CNT_W-1:0] cntInc;
	logic ctrlOpen;
	logic [3:0] wrSel;

	// the tick divider below cannot count past sixteen bits
	if (OSC_DIV < 2 || OSC_DIV > 65535) begin : g_bad_div
		$error("oscillator divider out of range");
	end

	// reserved codes fall back to the longest valid setting, the safe side for a watchdog
	function automatic logic [3:0] fix_code(input logic [3:0] code);
		fix_code = (code > TSEL_MAX) ? TSEL_MAX : code; // [R03]
	endfunction : fix_code

	wdt_osc_tick #(.DIV(OSC_DIV)) wdt_osc_tick_i (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.tick(tick)
	);

	assign acc = wb_cyc_i && wb_stb_i && !s_q.ack;
	assign wr = acc && wb_we_i && wb_sel_i[0];
	assign rd = acc && !wb_we_i;
	assign enabled = s_q.irqEn || s_q.rstEn;
	assign limit = CNT_W'(BASE_CYCLES) << s_q.tsel; // [R01] [R02]
	assign cntInc = s_q.cnt + CNT_W'(1);
	assign timeout = tick && enabled && (cntInc >= limit); // [R11] [R07]
	assign restart = wr && wb_adr_i == OFF_CMD && wb_dat_i[CMD_RESTART_BIT];
	// an accepted control write is the only path that may shorten the period or stop a reset-enabled count
	assign ctrlOpen = wr && wb_adr_i == OFF_CTRL && s_q.unlock != 3'h0; // [R05]
	assign wrSel = {wb_dat_i[TSEL_HI_BIT], wb_dat_i[2:0]};

	always_comb begin
		logic [3:0] newSel;
		logic [EVT_W-1:0] evt;
		logic setFlag;
		logic clrFlag;
		newSel = {wb_dat_i[TSEL_HI_BIT], wb_dat_i[2:0]};
		evt = '0;
		setFlag = 1'b0;
		clrFlag = 1'b0;
		s_d = s_q;
		s_d.ack = acc;
		s_d.rstReq = 1'b0;
		s_d.rdata = 32'h0000_0000;
		if (s_q.unlock != 3'h0) begin
			s_d.unlock = s_q.unlock - 3'h1;
		end
		if (wr && wb_adr_i == OFF_PROTECT && wb_dat_i[7:0] == UNLOCK_SIG) begin
			s_d.unlock = UNLOCK_WIN; // [R05]
		end
		if (wr && wb_adr_i == OFF_CTRL) begin
			s_d.irqEn = wb_dat_i[IRQEN_BIT];
			clrFlag = wb_dat_i[FLAG_BIT]; // [R09]
			if (s_q.unlock != 3'h0) begin
				// one write spends the window, like a real timed sequence
				s_d.tsel = fix_code(newSel); // [R03] [R05]
				s_d.rstEn = wb_dat_i[RSTEN_BIT];
				s_d.unlock = 3'h0;
			end else begin
				// enabling is free; changing the period or clearing reset enable is not
				s_d.rstEn = s_q.rstEn || wb_dat_i[RSTEN_BIT];
				if (fix_code(newSel) != s_q.tsel || (s_q.rstEn && !wb_dat_i[RSTEN_BIT])) begin
					evt[EVT_REJECT] = 1'b1; // [R05]
				end
			end
		end
		if (wr && wb_adr_i == OFF_CMD && wb_dat_i[CMD_VECTOR_BIT]) begin
			clrFlag = 1'b1; // [R09]
		end
		if (wr && wb_adr_i == OFF_STATUS) begin
			s_d.sts = s_q.sts & ~wb_dat_i[EVT_W-1:0];
		end
		if (wr && wb_adr_i == OFF_MASK) begin
			s_d.mask = wb_dat_i[EVT_W-1:0];
		end
		// a new period starts from zero, so the count never sits above a shorter limit
		if (restart || ctrlOpen || !enabled) begin
			s_d.cnt = '0; // [R10]
		end else if (tick) begin
			s_d.cnt = timeout ? CNT_W'(0) : cntInc; // [R07] [R11]
		end
		if (timeout) begin
			evt[EVT_TIMEOUT] = 1'b1;
			if (s_q.irqEn) begin
				setFlag = 1'b1; // [R08] [R09]
				if (s_q.rstEn) begin
					s_d.irqEn = 1'b0; // [R08]
				end
			end else begin
				s_d.rstReq = 1'b1; // [R06]
			end
		end
		// an interrupt time-out in the same cycle as a clear keeps the flag set
		s_d.flag = (s_q.flag && !clrFlag) || setFlag; // [R09]
		s_d.sts = s_d.sts | evt;
		s_d.irq = |(s_d.sts & s_d.mask);
		s_d.vec = RESET_VECTOR; // [R06]
		if (rd) begin
			unique case (wb_adr_i)
				OFF_CTRL: begin
					s_d.rdata[FLAG_BIT] = s_q.flag;
					s_d.rdata[IRQEN_BIT] = s_q.irqEn;
					s_d.rdata[TSEL_HI_BIT] = s_q.tsel[3];
					s_d.rdata[RSTEN_BIT] = s_q.rstEn;
					s_d.rdata[2:0] = s_q.tsel[2:0];
				end
				OFF_PROTECT: s_d.rdata[2:0] = s_q.unlock;
				OFF_STATUS: s_d.rdata[EVT_W-1:0] = s_q.sts;
				OFF_MASK: s_d.rdata[EVT_W-1:0] = s_q.mask;
				OFF_COUNT: s_d.rdata[CNT_W-1:0] = s_q.cnt;
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			s_q <= '0; // [R10]
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_dat_o = s_q.rdata;
	assign wb_ack_o = s_q.ack;
	assign irq = s_q.irq;
	assign timeoutIrqFlag = s_q.flag;
	assign resetReq = s_q.rstReq;
	assign resetVector = s_q.vec;

	sequence seq_sig_write;
		wr && wb_adr_i == OFF_PROTECT && wb_dat_i[7:0] == UNLOCK_SIG;
	endsequence

	sequence seq_quiet_window;
		(!wr) [*4];
	endsequence

	sequence seq_flag_clear;
		wr && ((wb_adr_i == OFF_CMD && wb_dat_i[CMD_VECTOR_BIT]) ||
			(wb_adr_i == OFF_CTRL && wb_dat_i[FLAG_BIT]));
	endsequence

	chk_reserved_code: assert property (@(posedge ref_clk) disable iff (!resetn) // [R03]
		s_q.tsel <= TSEL_MAX) else $error("reserved prescale code stored");

	chk_count_bound: assert property (@(posedge ref_clk) disable iff (!resetn) // [R02]
		s_q.cnt < limit) else $error("count passed selected limit");

	chk_locked_select: assert property (@(posedge ref_clk) disable iff (!resetn) // [R05]
		$changed(s_q.tsel) |-> $past(s_q.unlock) != 3'h0) else $error("select changed locked");

	chk_unlock_window: assert property (@(posedge ref_clk) disable iff (!resetn) // [R05]
		seq_sig_write ##1 seq_quiet_window |-> s_q.unlock == 3'h1 ##1 s_q.unlock == 3'h0)
		else $error("unlock window length wrong");

	chk_irq_flag_set: assert property (@(posedge ref_clk) disable iff (!resetn) // [R09]
		timeout && s_q.irqEn |=> s_q.flag) else $error("flag not set on time-out");

	chk_irq_to_reset: assert property (@(posedge ref_clk) disable iff (!resetn) // [R08]
		timeout && s_q.irqEn && s_q.rstEn |=> !s_q.irqEn && !s_q.rstReq)
		else $error("irq enable not cleared");

	chk_reset_pulse: assert property (@(posedge ref_clk) disable iff (!resetn) // [R06]
		timeout && !s_q.irqEn |=> s_q.rstReq && resetVector == 16'h0000 ##1 !s_q.rstReq)
		else $error("reset request wrong");

	chk_restart_clear: assert property (@(posedge ref_clk) disable iff (!resetn) // [R10]
		restart || !enabled |=> s_q.cnt == '0) else $error("counter not cleared");

	chk_tick_only: assert property (@(posedge ref_clk) disable iff (!resetn) // [R07]
		s_q.cnt != $past(s_q.cnt) && s_q.cnt != '0 |-> $past(tick))
		else $error("counter moved without tick");

	chk_wb_ack: assert property (@(posedge ref_clk) disable iff (!resetn)
		acc |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");

	chk_idle_data: assert property (@(posedge ref_clk) disable iff (!resetn)
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data outside ack");

	chk_unlock_open: assert property (@(posedge ref_clk) disable iff (!resetn) // [R05]
		seq_sig_write |=> s_q.unlock == UNLOCK_WIN) else $error("unlock window not opened");

	chk_window_closed: assert property (@(posedge ref_clk) disable iff (!resetn) // [R05]
		ctrlOpen |=> s_q.unlock == 3'h0) else $error("window left open after write");

	chk_locked_disable: assert property (@(posedge ref_clk) disable iff (!resetn) // [R05]
		$fell(s_q.rstEn) |-> $past(s_q.unlock) != 3'h0) else $error("disabled while locked");

	chk_reject_event: assert property (@(posedge ref_clk) disable iff (!resetn) // [R05]
		wr && wb_adr_i == OFF_CTRL && s_q.unlock == 3'h0 && wrSel <= TSEL_MAX &&
		wrSel != s_q.tsel |=> s_q.sts[EVT_REJECT]) else $error("rejected write not flagged");

	chk_select_fallback: assert property (@(posedge ref_clk) disable iff (!resetn) // [R03]
		ctrlOpen && wrSel > TSEL_MAX |=> s_q.tsel == TSEL_MAX)
		else $error("reserved code not replaced");

	chk_select_accept: assert property (@(posedge ref_clk) disable iff (!resetn) // [R01]
		ctrlOpen && wrSel <= TSEL_MAX |=> s_q.tsel == $past(wrSel))
		else $error("valid code not stored");

	chk_tick_pulse: assert property (@(posedge ref_clk) disable iff (!resetn) // [R07]
		tick |=> !tick) else $error("tick longer than one cycle");

	chk_count_step: assert property (@(posedge ref_clk) disable iff (!resetn) // [R07]
		tick && enabled && !timeout && !restart && !ctrlOpen |=>
		s_q.cnt == $past(s_q.cnt) + CNT_W'(1)) else $error("counter missed a tick");

	chk_timeout_limit: assert property (@(posedge ref_clk) disable iff (!resetn) // [R11]
		timeout |-> s_q.cnt == limit - CNT_W'(1) ##1 s_q.cnt == '0)
		else $error("time-out not at selected count");

	chk_stopped_quiet: assert property (@(posedge ref_clk) disable iff (!resetn) // [R01]
		!enabled |=> !s_q.rstReq && !$rose(s_q.flag)) else $error("stopped watchdog fired");

	chk_irq_not_reset: assert property (@(posedge ref_clk) disable iff (!resetn) // [R08]
		timeout && s_q.irqEn |=> !s_q.rstReq) else $error("reset in interrupt mode");

	chk_vector_value: assert property (@(posedge ref_clk) disable iff (!resetn) // [R06]
		resetReq |-> resetVector == RESET_VECTOR) else $error("reset vector wrong");

	// the core may clear the flag in the same cycle as a new time-out; the set must win
	chk_flag_clear: assert property (@(posedge ref_clk) disable iff (!resetn) // [R09]
		seq_flag_clear ##0 !(timeout && s_q.irqEn) |=> !s_q.flag)
		else $error("flag not cleared");

	chk_flag_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // [R09]
		s_q.flag && !(wr && (wb_adr_i == OFF_CMD || wb_adr_i == OFF_CTRL)) |=> s_q.flag)
		else $error("flag lost without clear");

	chk_status_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_q.sts[EVT_TIMEOUT] && !(wr && wb_adr_i == OFF_STATUS) |=> s_q.sts[EVT_TIMEOUT])
		else $error("status bit lost without clear");

	chk_timeout_irq: assert property (@(posedge ref_clk) disable iff (!resetn)
		timeout && s_q.mask[EVT_TIMEOUT] && !(wr && wb_adr_i == OFF_MASK) |=> irq)
		else $error("unmasked time-out without irq");
endmodule : watchdog_timeout_prescaler

// ===== pkg/wdt_pkg.sv
/*
 watchdog time-out prescaler constants: register map, field positions, timing.
 assumes a 100 MHz system clock and a 32 kHz watchdog oscillator derived from it.
*/
package wdt_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int OSC_HZ = 32_000;
	localparam int OSC_DIV = CLK_HZ / OSC_HZ;
	localparam int CNT_W = 19;
	localparam int BASE_CYCLES = 512;
	localparam int EVT_W = 2;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PROTECT = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_MASK = 8'h0c;
	localparam logic [7:0] OFF_COUNT = 8'h10;
	localparam logic [7:0] OFF_CMD = 8'h14;
	localparam int FLAG_BIT = 7;
	localparam int IRQEN_BIT = 6;
	localparam int TSEL_HI_BIT = 5;
	localparam int RSTEN_BIT = 3;
	localparam int CMD_RESTART_BIT = 0;
	localparam int CMD_VECTOR_BIT = 1;
	localparam int EVT_TIMEOUT = 0;
	localparam int EVT_REJECT = 1;
	localparam logic [3:0] TSEL_MAX = 4'h9;
	localparam logic [3:0] TSEL_RESET = 4'h0;
	localparam logic [7:0] UNLOCK_SIG = 8'hd8;
	localparam logic [2:0] UNLOCK_WIN = 3'h4;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
endpackage : wdt_pkg

// ===== design/wdt_osc_tick.sv
/*
 divider that stands in for the 32 kHz watchdog oscillator as a one-cycle enable.
 assumes a single free-running system clock.
*/
`timescale 1ns/100ps
module wdt_osc_tick #(
	parameter int DIV = wdt_pkg::OSC_DIV
) (
	input wire logic ref_clk,
	input wire logic resetn,
	output logic tick
);
	import wdt_pkg::*;

	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} state_s;

	state_s s_q;
	state_s s_d;

	if (DIV < 2 || DIV > 65535) begin : g_bad_div
		$error("divider out of range");
	end

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.cnt == 16'(DIV - 1)) begin
			s_d.cnt = 16'h0000;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;
endmodule : wdt_osc_tick

// ===== tb/watchdog_timeout_prescaler_bench.sv
/*
 bench for the watchdog time-out prescaler: wishbone tasks and directed tests.
 assumes wdt_pkg is compiled first; the oscillator divider is cut to 4 cycles.
*/
`timescale 1ns/100ps
module watchdog_timeout_prescaler_bench;
	import wdt_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic irq;
	logic timeoutIrqFlag;
	logic resetReq;
	logic [15:0] resetVector;
	logic [31:0] rd;
	int failCount = 0;
	int cmpCount = 0;
	always #5 ref_clk = ~ref_clk;
	watchdog_timeout_prescaler #(.OSC_DIV(4)) watchdog_timeout_prescaler_i (
		.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
		.timeoutIrqFlag(timeoutIrqFlag), .resetReq(resetReq), .resetVector(resetVector));
	task automatic giveVerdict();
		$display("compares %0d mismatches %0d", cmpCount, failCount);
		if (failCount == 0 && cmpCount > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : giveVerdict
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			failCount++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check
	// request held until ack is sampled high, then released
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hf;
		wb_dat_i <= dat;
		@(posedge ref_clk);
		while (wb_ack_o !== 1'b1) begin
			n++;
			if (n > 20) begin
				check(32'h0, 32'h1);
				giveVerdict();
			end
			@(posedge ref_clk);
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : bus
	task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
		bus(1'b0, adr, 32'h0);
		check(rd, exp);
	endtask : rdChk
	task automatic unlock();
		bus(1'b1, OFF_PROTECT, {24'h0, UNLOCK_SIG});
	endtask : unlock
	// latency window catches a wrong doubling; divider phase needs the slack
	task automatic waitEvt(input bit wantFlag, input int lo, input int hi);
		int n;
		bit sawReset;
		n = 0;
		sawReset = 1'b0;
		do begin
			@(posedge ref_clk);
			n++;
			sawReset |= (resetReq === 1'b1);
		end while ((wantFlag ? timeoutIrqFlag : resetReq) !== 1'b1 && n < hi);
		check({31'h0, n >= lo && n < hi}, 32'h1);
		if (wantFlag) check({31'h0, sawReset}, 32'h0);
		if (n >= hi) giveVerdict();
	endtask : waitEvt
	initial begin
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		rdChk(OFF_CTRL, 32'h0);
		rdChk(OFF_COUNT, 32'h0);
		bus(1'b1, 8'h3c, 32'hff);
		rdChk(8'h3c, 32'h0);
		$display("test reset values done");
		unlock();
		bus(1'b1, OFF_CTRL, 32'h2f);
		rdChk(OFF_CTRL, 32'h29);
		$display("test reserved code done");
		bus(1'b1, OFF_CTRL, 32'h09);
		rdChk(OFF_CTRL, 32'h29);
		rdChk(OFF_STATUS, 32'h2);
		bus(1'b1, OFF_STATUS, 32'h2);
		unlock();
		rdChk(OFF_PROTECT, 32'h2);
		repeat (4) @(posedge ref_clk);
		bus(1'b1, OFF_CTRL, 32'h09);
		rdChk(OFF_CTRL, 32'h29);
		bus(1'b1, OFF_STATUS, 32'h2);
		rdChk(OFF_STATUS, 32'h0);
		$display("test locked writes done");
		unlock();
		bus(1'b1, OFF_CTRL, 32'h08);
		bus(1'b1, OFF_CMD, 32'h1);
		waitEvt(1'b0, 2035, 2060);
		check({16'h0, resetVector}, 32'h0);
		@(posedge ref_clk);
		check({31'h0, resetReq}, 32'h0);
		rdChk(OFF_STATUS, 32'h1);
		bus(1'b1, OFF_STATUS, 32'h1);
		$display("test reset time-out done");
		bus(1'b1, OFF_MASK, 32'h1);
		unlock();
		bus(1'b1, OFF_CTRL, 32'h49);
		bus(1'b1, OFF_CMD, 32'h1);
		waitEvt(1'b1, 4085, 4110);
		@(posedge ref_clk);
		check({31'h0, irq}, 32'h1);
		rdChk(OFF_CTRL, 32'h89);
		bus(1'b1, OFF_CMD, 32'h2);
		check({31'h0, timeoutIrqFlag}, 32'h0);
		bus(1'b1, OFF_STATUS, 32'h1);
		@(posedge ref_clk);
		check({31'h0, irq}, 32'h0);
		bus(1'b1, OFF_CMD, 32'h1);
		waitEvt(1'b0, 4085, 4110);
		bus(1'b1, OFF_CTRL, 32'h49);
		bus(1'b1, OFF_CMD, 32'h1);
		waitEvt(1'b1, 4085, 4110);
		bus(1'b1, OFF_CTRL, 32'hc9);
		@(posedge ref_clk);
		check({31'h0, timeoutIrqFlag}, 32'h0);
		$display("test interrupt time-out done");
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		rdChk(OFF_CTRL, 32'h0);
		rdChk(OFF_COUNT, 32'h0);
		check({30'h0, irq, timeoutIrqFlag}, 32'h0);
		$display("test chip reset done");
		bus(1'b1, OFF_CTRL, 32'h08);
		bus(1'b1, OFF_CTRL, 32'h00);
		rdChk(OFF_CTRL, 32'h08);
		rdChk(OFF_STATUS, 32'h2);
		bus(1'b1, OFF_STATUS, 32'h2);
		repeat (20) @(posedge ref_clk);
		$display("test locked disable done");
		unlock();
		bus(1'b1, OFF_CTRL, 32'h00);
		rdChk(OFF_COUNT, 32'h0);
		$display("test disable done");
		giveVerdict();
	end
endmodule : watchdog_timeout_prescaler_bench
